// ### testbench/cache_maintenance_op_unit_bench.sv
// Self-checking bench for the cache maintenance unit
`timescale 1ns/1ps
module cache_maintenance_op_unit_bench import cmo_pkg::*;;
	localparam logic [1:0] SD = SEL_DCACHE;
	localparam logic [1:0] SI = SEL_ICACHE;
	localparam logic [INDEX_BITS-1:0] IX = 8'h3C;
	localparam logic [TAG_W-1:0] TA = 20'hABCDE;
	localparam logic [TAG_W-1:0] TB = 20'h12345;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic issue_valid, issue_busy, xlate_req, mem_valid, mem_done, mem_err;
	logic done, e, refill, inval, err_mode, kern, cope;
	logic [3:0] lat;
	logic [VA_W-1:0] xlate_vaddr;
	logic [PA_W-1:0] last_addr;
	issue_s issue;
	xlate_s xlate;
	mem_req_s mem_req;
	exc_e exc;
	int nwr, nrd, error_cnt, checked;

	cache_maintenance_op_unit u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .issue_valid(issue_valid), .issue(issue),
		.issue_busy(issue_busy), .xlate_vaddr(xlate_vaddr),
		.xlate_req(xlate_req), .xlate(xlate), .mem_req(mem_req),
		.mem_valid(mem_valid), .mem_done(mem_done), .mem_err(mem_err),
		.done(done), .exc(exc));
	cmo_far_model u_far (.pclk(pclk), .presetn(presetn),
		.xlate_vaddr(xlate_vaddr), .xlate(xlate), .refill(refill),
		.inval(inval), .mem_req(mem_req), .mem_valid(mem_valid),
		.mem_done(mem_done), .mem_err(mem_err), .err_mode(err_mode),
		.lat(lat), .nwr(nwr), .nrd(nrd), .last_addr(last_addr));

	always #2 pclk = ~pclk;

	task automatic end_of_test();
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] x, g);
		checked++;
		if (g !== x) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic wait_for(ref logic s);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (s !== 1'b1 && n < 200);
		if (n >= 200) begin
			error_cnt++;
			end_of_test();
		end
	endtask

	task automatic apb(input logic w, input logic [APB_AW-1:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		wait_for(pready);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [63:0] va(input logic [TAG_W-1:0] t);
		return {32'h0, t, IX, {LINE_BITS{1'b0}}};
	endfunction

	task automatic run(input logic [1:0] s, input logic [2:0] c,
		input logic [63:0] b, input logic [15:0] o, input exc_e x,
		input int ew, er, input logic [63:0] ea);
		int w0, r0;
		w0 = nwr;
		r0 = nrd;
		issue_valid <= 1'b1;
		issue <= '{instr: {6'h2F, 5'h00, c, s, o}, base: b,
			kernel: kern, cop_enable: cope};
		@(posedge pclk);
		issue_valid <= 1'b0;
		wait_for(done);
		chk("exc", x, exc);
		chk("writes", ew, nwr - w0);
		chk("reads", er, nrd - r0);
		if (ew > 0)
			chk("write address", ea, last_addr);
	endtask

	task automatic set_line(input logic [1:0] s, input logic [TAG_W-1:0] t,
		input logic [31:0] vd);
		apb(1'b1, ADDR_TAG_LOW, {12'h000, t});
		apb(1'b1, ADDR_TAG_HIGH, vd);
		run(s, OP_STORE_TAG, va(t), 16'h0000, EXC_NONE, 0, 0, 0);
	endtask

	task automatic t_regs();
		apb(1'b0, ADDR_TAG_LOW, 0);
		chk("tag low", TAG_LOW_RST, r);
		apb(1'b0, ADDR_TAG_HIGH, 0);
		chk("tag high", TAG_HIGH_RST, r);
		apb(1'b0, ADDR_ECC, 0);
		chk("ecc", ECC_RST, r);
		apb(1'b1, 12'h100, 32'hFFFF_FFFF);
		chk("unmapped error", 1, e);
	endtask

	task automatic t_index();
		set_line(SD, TA, 32'h3);
		run(SD, OP_IDX_INV, va(TB), 16'h0, EXC_NONE, 1, 0, va(TA));
		run(SD, OP_IDX_INV, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		set_line(SI, TA, 32'h3);
		run(SI, OP_IDX_INV, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		run(SI, OP_HIT_WB, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		set_line(SD, TA, 32'h1);
		apb(1'b1, ADDR_TAG_LOW, 0);
		run(SD, OP_LOAD_TAG, va(TB), 16'h0, EXC_NONE, 0, 0, 0);
		apb(1'b0, ADDR_TAG_LOW, 0);
		chk("loaded tag", TA, r[TAG_W-1:0]);
		run(SD, OP_HIT_INV, va(TB) + 64'h1_0000_0010, 16'hFFF0,
			EXC_NONE, 0, 0, 0);
		chk("vaddr", va(TB) + 64'h1_0000_0000, xlate_vaddr);
	endtask

	task automatic t_hit();
		set_line(SD, TA, 32'h3);
		run(SD, OP_HIT_WB, va(TB), 16'h0, EXC_NONE, 0, 0, 0);
		run(SD, OP_HIT_WB, va(TA), 16'h0, EXC_NONE, 1, 0, va(TA));
		run(SD, OP_HIT_WB, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		run(SD, OP_HIT_WB_INV, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		run(SD, OP_HIT_WB, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		set_line(SD, TA, 32'h3);
		run(SD, OP_HIT_INV, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		run(SD, OP_HIT_WB, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		set_line(SD, TA, 32'h3);
		lat <= 4'h6;
		run(SD, OP_HIT_WB_INV, va(TA), 16'h0, EXC_NONE, 1, 0, va(TA));
		lat <= 4'h0;
		set_line(SD, TA, 32'h3);
		run(SD, OP_CREATE_DIRTY, va(TB), 16'h0, EXC_NONE, 1, 0, va(TA));
		run(SD, OP_HIT_WB, va(TB), 16'h0, EXC_NONE, 1, 0, va(TB));
		set_line(SI, TA, 32'h1);
		run(SI, OP_HIT_WB, va(TA), 16'h0, EXC_NONE, 1, 0, va(TA));
		run(SI, OP_HIT_WB_INV, va(TB), 16'h0, EXC_NONE, 0, 1, 0);
		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		apb(1'b1, ADDR_ECC, 32'h0000_005A);
		run(SI, OP_HIT_WB_INV, va(TA), 16'h0, EXC_NONE, 0, 1, 0);
		run(SI, OP_LOAD_TAG, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		apb(1'b0, ADDR_ECC, 0);
		chk("fill parity", 32'h0000_005A, r);
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
	endtask

	task automatic t_exc();
		set_line(SD, TA, 32'h3);
		kern = 1'b0;
		cope = 1'b0;
		run(SD, OP_IDX_INV, va(TA), 16'h0, EXC_COP_UNUSABLE, 0, 0, 0);
		kern = 1'b1;
		cope = 1'b1;
		refill <= 1'b1;
		run(SD, OP_IDX_INV, va(TA), 16'h0, EXC_TLB_REFILL, 0, 0, 0);
		refill <= 1'b0;
		inval <= 1'b1;
		run(SI, OP_HIT_INV, va(TA), 16'h0, EXC_TLB_INVALID, 0, 0, 0);
		inval <= 1'b0;
		run(2'h2, OP_IDX_INV, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		run(SD, 3'h7, va(TA), 16'h0, EXC_NONE, 0, 0, 0);
		run(SI, OP_CREATE_DIRTY, va(TB), 16'h0, EXC_NONE, 0, 0, 0);
		err_mode <= 1'b1;
		run(SD, OP_HIT_WB, va(TA), 16'h0, EXC_BUS_ERROR, 1, 0, va(TA));
		err_mode <= 1'b0;
		apb(1'b0, ADDR_STATUS, 0);
		chk("status", {24'h0, 1'b0, EXC_BUS_ERROR, 3'h6}, r);
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, issue_valid} = '0;
		{refill, inval, err_mode} = '0;
		{kern, cope} = 2'h3;
		paddr = '0;
		pwdata = '0;
		issue = '0;
		lat = 4'h0;
		error_cnt = 0;
		checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_index();
		t_hit();
		t_exc();
		end_of_test();
	end
endmodule

// ### testbench/cmo_far_model.sv
// Translation and main memory model facing the maintenance unit
`timescale 1ns/1ps
module cmo_far_model import cmo_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [VA_W-1:0] xlate_vaddr,
	output xlate_s xlate,
	input wire logic refill,
	input wire logic inval,
	input mem_req_s mem_req,
	input wire logic mem_valid,
	output logic mem_done,
	output logic mem_err,
	input wire logic err_mode,
	input wire logic [3:0] lat,
	output int nwr,
	output int nrd,
	output logic [PA_W-1:0] last_addr
);
	logic [3:0] wait_q;
	// Identity mapped, always cached translation
	assign xlate = '{refill: refill, invalid: inval, addr_err: 1'b0,
		uncached: 1'b0, paddr: xlate_vaddr[PA_W-1:0]};
	// Memory answers lat+1 cycles after mem_valid rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 4'h0;
			mem_done <= 1'b0;
			mem_err <= 1'b0;
			nwr <= 0;
			nrd <= 0;
			last_addr <= '0;
		end else if (mem_done) begin
			mem_done <= 1'b0;
			mem_err <= ~mem_err;
			wait_q <= 4'h0;
		end else if (mem_valid && wait_q >= lat) begin
			mem_done <= 1'b1;
			mem_err <= err_mode;
			last_addr <= mem_req.addr;
			if (mem_req.write)
				nwr <= nwr + 1;
			else
				nrd <= nrd + 1;
		end else begin
			mem_err <= ~mem_err;
			wait_q <= mem_valid ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule

// ### verilog/cache_maintenance_op_unit.sv
// Cache maintenance operation unit with APB register access
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
// How it works
// R1: Write-back address comes from the line's tag, not the translation.
// R2: Any operation may take TLB refill or TLB invalid exceptions.
// R3: Index operations index by address, never needing a tag match.
// R4: No TLB modified exception is ever raised here.
// R5: Bits 17:16 select cache; 0 instruction, 1 data, 2-3 undefined.
// R6: Bits 20:18 hold the operation, decoded with the cache select.
// R7: Op 0 on instruction cache invalidates the indexed line.
// R8: Op 0 on data cache writes back valid dirty line, then invalidates.
// R9: Op 1 loads tag into tag_low_reg and parity into ECC register.
// R10: Op 2 writes the indexed tag from tag_low_reg and tag_high_reg.
// R11: Op 3 writes back a foreign dirty line, then marks line dirty.
// R12: Op 4 invalidates the line only on a hit, no write-back.
// R13: Op 5 on data cache: on hit, write back if dirty, invalidate.
// R14: Op 5 on instruction cache fills; override parity from ECC if set.
// R15: Op 6 on data cache: on dirty hit, write back, clear dirty.
// R16: Op 6 on instruction cache: on hit, always write back.
// R17: Address is base plus sign-extended offset, translated as data.
// R18: Without coprocessor access outside kernel, raise unusable exception.
// R19: Hit operations do nothing on an invalid or foreign line.
// R20: Software avoids uncached addresses and unlisted combinations.
// R21: Undefined combinations change no state and write no memory.
// R22: Retire only after memory transfer; failing transfer is bus error.
module cache_maintenance_op_unit import cmo_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic issue_valid,
	input issue_s issue,
	output logic issue_busy,
	output logic [VA_W-1:0] xlate_vaddr,
	output logic xlate_req,
	input xlate_s xlate,
	output mem_req_s mem_req,
	output logic mem_valid,
	input wire logic mem_done,
	input wire logic mem_err,
	output logic done,
	output exc_e exc
);
	typedef enum logic [2:0] {
		S_IDLE, S_XLATE, S_EXEC, S_MEM, S_UPDATE, S_FINISH
	} state_e;

	state_e state_q;
	issue_s cur_q;
	xlate_s xl_q;
	logic [31:0] tag_low_reg_q;
	logic [31:0] tag_high_reg_q;
	logic [31:0] ecc_q;
	logic parity_override_q;
	logic [VA_W-1:0] vaddr_q;
	logic busy_q;
	logic done_q;
	exc_e exc_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic xlate_req_q;
	mem_req_s mem_req_q;
	logic mem_valid_q;
	logic [1:0] last_op_q;

	logic [1:0] sel;
	logic [2:0] op;
	logic is_d;
	logic is_i;
	logic [INDEX_BITS-1:0] idx;
	logic hit;
	logic legal;
	line_s d_line;
	line_s i_line;
	line_s cur_line;
	logic [PAR_W-1:0] d_par;
	logic [PAR_W-1:0] i_par;
	logic [PAR_W-1:0] cur_par;
	logic need_wb;
	logic need_fill;
	logic wr_line;
	line_s new_line;
	logic [PAR_W-1:0] new_par;
	logic [VA_W-1:0] vaddr_d;

	assign sel = cur_q.instr[SEL_LO+1:SEL_LO]; // [R5]
	assign op = cur_q.instr[OP_LO+2:OP_LO]; // [R6]
	assign is_i = (sel == SEL_ICACHE);
	assign is_d = (sel == SEL_DCACHE);
	// Index taken straight from the address, no tag match needed [R3]
	assign idx = xl_q.paddr[LINE_BITS+INDEX_BITS-1:LINE_BITS];
	assign cur_line = is_d ? d_line : i_line;
	assign cur_par = is_d ? d_par : i_par;
	assign hit = cur_line.valid &&
		(cur_line.tag == xl_q.paddr[PA_W-1:LINE_BITS+INDEX_BITS]);

	// Legal combinations; others do nothing [R21]
	always_comb begin
		legal = 1'b0;
		if (is_i) begin
			legal = (op != OP_CREATE_DIRTY) && (op != 3'h7);
		end else if (is_d) begin
			legal = (op != 3'h7);
		end
	end

	// Sign-extended offset plus base [R17]
	assign vaddr_d = issue.base +
		{{(VA_W-OFS_W){issue.instr[OFS_W-1]}}, issue.instr[OFS_W-1:0]};

	cmo_tag_store u_dtags (
		.pclk(pclk),
		.presetn(presetn),
		.rd_idx(idx),
		.rd_line(d_line),
		.rd_par(d_par),
		.wr_en(wr_line && is_d),
		.wr_idx(idx),
		.wr_line(new_line),
		.wr_par(new_par)
	);

	cmo_tag_store u_itags (
		.pclk(pclk),
		.presetn(presetn),
		.rd_idx(idx),
		.rd_line(i_line),
		.rd_par(i_par),
		.wr_en(wr_line && is_i),
		.wr_idx(idx),
		.wr_line(new_line),
		.wr_par(new_par)
	);

	// Memory transfer decision
	always_comb begin
		need_wb = 1'b0;
		need_fill = 1'b0;
		if (legal) begin
			unique case (op)
				OP_IDX_INV: need_wb = is_d && cur_line.valid &&
					cur_line.dirty; // [R8]
				OP_CREATE_DIRTY: need_wb = !hit && cur_line.valid &&
					cur_line.dirty; // [R11]
				OP_HIT_WB_INV: begin
					need_wb = is_d && hit && cur_line.dirty; // [R13]
					need_fill = is_i; // [R14]
				end
				OP_HIT_WB: need_wb = hit && (is_i || cur_line.dirty); // [R15] [R16]
				default: begin
					need_wb = 1'b0;
					need_fill = 1'b0;
				end
			endcase
		end
	end

	// Line update, applied at S_UPDATE
	always_comb begin
		wr_line = 1'b0;
		new_line = cur_line;
		new_par = cur_par;
		if (state_q == S_UPDATE && legal) begin
			unique case (op)
				OP_IDX_INV: begin
					wr_line = 1'b1; // [R7] [R8]
					new_line.valid = 1'b0;
					new_line.dirty = 1'b0;
				end
				OP_STORE_TAG: begin
					wr_line = 1'b1; // [R10]
					new_line.tag = tag_low_reg_q[TAG_W-1:0];
					new_line.valid = tag_high_reg_q[0];
					new_line.dirty = tag_high_reg_q[1];
				end
				OP_CREATE_DIRTY: begin
					wr_line = 1'b1; // [R11]
					new_line.valid = 1'b1;
					new_line.dirty = 1'b1;
					new_line.tag = xl_q.paddr[PA_W-1:LINE_BITS+INDEX_BITS];
				end
				OP_HIT_INV: begin
					wr_line = hit; // [R12] [R19]
					new_line.valid = 1'b0;
				end
				OP_HIT_WB_INV: begin
					wr_line = is_i || hit; // [R13] [R14] [R19]
					new_line.valid = is_i;
					new_line.dirty = 1'b0;
					new_line.tag = xl_q.paddr[PA_W-1:LINE_BITS+INDEX_BITS];
					new_par = parity_override_q ? ecc_q[PAR_W-1:0] :
						^xl_q.paddr ? 8'hFF : 8'h00; // [R14]
				end
				OP_HIT_WB: begin
					wr_line = is_d && hit && cur_line.dirty; // [R15]
					new_line.dirty = 1'b0;
				end
				default: wr_line = 1'b0;
			endcase
		end
	end

	// Operation sequencer; never raises TLB modified [R4]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			cur_q <= '0;
			xl_q <= '0;
			vaddr_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			exc_q <= EXC_NONE;
			xlate_req_q <= 1'b0;
			mem_req_q <= '0;
			mem_valid_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			xlate_req_q <= 1'b0;
			unique case (state_q)
				S_IDLE: if (issue_valid) begin
					cur_q <= issue;
					vaddr_q <= vaddr_d;
					busy_q <= 1'b1;
					exc_q <= EXC_NONE;
					if (!issue.kernel && !issue.cop_enable) begin
						exc_q <= EXC_COP_UNUSABLE; // [R18]
						state_q <= S_FINISH;
					end else begin
						xlate_req_q <= 1'b1;
						state_q <= S_XLATE;
					end
				end
				S_XLATE: begin
					xl_q <= xlate;
					if (xlate.refill) begin
						exc_q <= EXC_TLB_REFILL; // [R2]
						state_q <= S_FINISH;
					end else if (xlate.invalid) begin
						exc_q <= EXC_TLB_INVALID; // [R2]
						state_q <= S_FINISH;
					end else if (xlate.addr_err) begin
						exc_q <= EXC_ADDR_ERROR;
						state_q <= S_FINISH;
					end else begin
						state_q <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (need_wb || need_fill) begin
						mem_valid_q <= 1'b1;
						mem_req_q.write <= need_wb;
						// Write-back address built from the stored tag [R1]
						mem_req_q.addr <= need_wb ?
							{cur_line.tag, idx, {LINE_BITS{1'b0}}} :
							{xl_q.paddr[PA_W-1:LINE_BITS],
							{LINE_BITS{1'b0}}};
						state_q <= S_MEM;
					end else begin
						state_q <= S_UPDATE;
					end
				end
				S_MEM: if (mem_done) begin
					mem_valid_q <= 1'b0;
					if (mem_err) begin
						exc_q <= EXC_BUS_ERROR; // [R22]
						state_q <= S_FINISH;
					end else begin
						state_q <= S_UPDATE;
					end
				end
				S_UPDATE: state_q <= S_FINISH;
				S_FINISH: begin
					done_q <= 1'b1; // [R22]
					busy_q <= 1'b0;
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Tag load into tag_low_reg and ECC, parity errors ignored [R9]
	logic load_tag;
	assign load_tag = state_q == S_UPDATE && legal && op == OP_LOAD_TAG;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_low_reg_q <= TAG_LOW_RST;
			tag_high_reg_q <= TAG_HIGH_RST;
			ecc_q <= ECC_RST;
			parity_override_q <= 1'b0;
		end else if (load_tag) begin
			tag_low_reg_q <= {{(32-TAG_W-2){1'b0}}, cur_line.valid,
				cur_line.dirty, cur_line.tag}; // [R9]
			ecc_q <= {{(32-PAR_W){1'b0}}, cur_par}; // [R9]
		end else if (psel && penable && pwrite) begin
			unique case (paddr)
				ADDR_TAG_LOW: tag_low_reg_q <= pwdata;
				ADDR_TAG_HIGH: tag_high_reg_q <= pwdata;
				ADDR_ECC: ecc_q <= pwdata;
				ADDR_CTRL: parity_override_q <= pwdata[0];
				default: parity_override_q <= parity_override_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_op_q <= 2'h0;
		end else if (done_q) begin
			last_op_q <= {exc_q != EXC_NONE, 1'b1};
		end
	end

	// APB slave, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			if (psel && !penable) begin
				unique case (paddr)
					ADDR_TAG_LOW: prdata_q <= tag_low_reg_q;
					ADDR_TAG_HIGH: prdata_q <= tag_high_reg_q;
					ADDR_ECC: prdata_q <= ecc_q;
					ADDR_CTRL: prdata_q <= {31'h0, parity_override_q};
					ADDR_STATUS: prdata_q <= {24'h0, 1'b0, exc_q,
						last_op_q, busy_q};
					default: pslverr_q <= 1'b1;
				endcase
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign issue_busy = busy_q;
	assign xlate_vaddr = vaddr_q;
	assign xlate_req = xlate_req_q;
	assign mem_req = mem_req_q;
	assign mem_valid = mem_valid_q;
	assign done = done_q;
	assign exc = exc_q;

	// Retirement steps after an exception
	sequence s_refill_retire;
		done_q && exc_q == EXC_TLB_REFILL;
	endsequence
	sequence s_unusable_retire;
		exc_q == EXC_COP_UNUSABLE ##1 done_q;
	endsequence

	a_wb_addr_tag: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		state_q == S_EXEC && need_wb |=> mem_req_q.addr ==
		{$past(cur_line.tag), $past(idx), {LINE_BITS{1'b0}}})
		else $error("write-back not at tag address");
	a_refill_exc: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		state_q == S_XLATE && xlate.refill |=> ##1 s_refill_retire)
		else $error("refill exception missing");
	a_cop_unusable: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
		state_q == S_IDLE && issue_valid && !issue.kernel &&
		!issue.cop_enable |=> s_unusable_retire)
		else $error("unusable exception missing");
	a_done_after_mem: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
		mem_valid_q && !mem_done |=> !done_q)
		else $error("retired during memory transfer");
	a_bus_error: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
		state_q == S_MEM && mem_done && mem_err |=> exc_q == EXC_BUS_ERROR)
		else $error("bus error not raised");
	a_undef_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
		!legal && state_q == S_EXEC |=> !mem_valid_q ##1
		cur_line == $past(cur_line)) else $error("undefined op changed state");
	a_miss_no_wr: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
		state_q == S_UPDATE && op == OP_HIT_INV && !hit |-> !wr_line)
		else $error("hit op acted on miss");
	a_no_modified: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		state_q == S_XLATE && !xlate.refill && !xlate.invalid &&
		!xlate.addr_err |=> exc_q == EXC_NONE)
		else $error("unexpected exception");
	a_vaddr_form: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		state_q == S_IDLE && issue_valid |=> vaddr_q == $past(issue.base) +
		VA_W'($signed($past(issue.instr[OFS_W-1:0]))))
		else $error("virtual address wrong");
endmodule

// ### verilog/cmo_pkg.sv
// Package: constants and carriers for the cache maintenance unit
package cmo_pkg;
	localparam int VA_W = 64;
	localparam int PA_W = 32;
	localparam int OFS_W = 16;
	localparam int SEL_LO = 16;
	localparam int OP_LO = 18;
	localparam int BASE_LO = 21;
	localparam logic [1:0] SEL_ICACHE = 2'h0;
	localparam logic [1:0] SEL_DCACHE = 2'h1;
	localparam logic [2:0] OP_IDX_INV = 3'h0;
	localparam logic [2:0] OP_LOAD_TAG = 3'h1;
	localparam logic [2:0] OP_STORE_TAG = 3'h2;
	localparam logic [2:0] OP_CREATE_DIRTY = 3'h3;
	localparam logic [2:0] OP_HIT_INV = 3'h4;
	localparam logic [2:0] OP_HIT_WB_INV = 3'h5;
	localparam logic [2:0] OP_HIT_WB = 3'h6;
	localparam int LINE_BITS = 4;
	localparam int INDEX_BITS = 8;
	localparam int TAG_W = PA_W - LINE_BITS - INDEX_BITS;
	localparam int PAR_W = 8;
	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] ADDR_TAG_LOW = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_TAG_HIGH = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_ECC = 12'h008;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h00C;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h010;
	localparam logic [31:0] TAG_LOW_RST = 32'h0000_0000;
	localparam logic [31:0] TAG_HIGH_RST = 32'h0000_0000;
	localparam logic [31:0] ECC_RST = 32'h0000_0000;

	typedef enum logic [3:0] {
		EXC_NONE, EXC_COP_UNUSABLE, EXC_TLB_REFILL, EXC_TLB_INVALID,
		EXC_BUS_ERROR, EXC_ADDR_ERROR
	} exc_e;

	// Issue from the pipeline
	typedef struct packed {
		logic [31:0] instr;
		logic [VA_W-1:0] base;
		logic kernel;
		logic cop_enable;
	} issue_s;

	// Translation answer
	typedef struct packed {
		logic refill;
		logic invalid;
		logic addr_err;
		logic uncached;
		logic [PA_W-1:0] paddr;
	} xlate_s;

	// Tag entry of one cache line
	typedef struct packed {
		logic valid;
		logic dirty;
		logic [TAG_W-1:0] tag;
	} line_s;

	// Memory request
	typedef struct packed {
		logic write;
		logic [PA_W-1:0] addr;
	} mem_req_s;
endpackage

// ### verilog/cmo_tag_store.sv
// Tag array of one primary cache, one read and one write port
`timescale 1ns/1ps
module cmo_tag_store import cmo_pkg::*; #(
	parameter int IDX_W = INDEX_BITS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [IDX_W-1:0] rd_idx,
	output line_s rd_line,
	output logic [PAR_W-1:0] rd_par,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input line_s wr_line,
	input wire logic [PAR_W-1:0] wr_par
);
	line_s lines_q [2**IDX_W];
	logic [PAR_W-1:0] par_q [2**IDX_W];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2**IDX_W; i++) begin
				lines_q[i] <= '0;
				par_q[i] <= '0;
			end
		end else if (wr_en) begin
			lines_q[wr_idx] <= wr_line;
			par_q[wr_idx] <= wr_par;
		end
	end

	assign rd_line = lines_q[rd_idx];
	assign rd_par = par_q[rd_idx];
endmodule
